/* hdl/mil_top.sv */
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mil_params.svh"

module mil_top #(
    parameter bit EXT_RISING = 1'b1
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire mil_pkg::mil_addr_t paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // request sources
    input  wire logic             timer_zero_ovf,
    input  wire logic             conv_done,
    input  wire logic             ext_irq_pin,
    input  wire logic [2:0]       port_pins,
    // core sequencer
    input  wire logic             cycle_strobe,
    input  wire logic             return_from_irq_instr,
    output logic                  vector_take,
    output logic                  push_return,
    output logic                  pc_load,
    output mil_pkg::mil_pc_t      pc_vector,
    // system interrupt
    output logic                  irq
);
    import mil_pkg::*;

    mil_top_s r;
    mil_top_s next_r;

    logic       ext_s;
    logic [2:0] port_s;
    logic       lat_take;
    logic       request;

    function automatic mil_sel_e decode(input mil_addr_t a);
        case (a)
            `MIL_OFF_CTRL:  decode = MIL_SEL_CTRL;
            `MIL_OFF_PFLAG: decode = MIL_SEL_PFLAG;
            `MIL_OFF_PEN:   decode = MIL_SEL_PEN;
            `MIL_OFF_STAT:  decode = MIL_SEL_STAT;
            `MIL_OFF_MASK:  decode = MIL_SEL_MASK;
            default:        decode = MIL_SEL_NONE;
        endcase
    endfunction

    function automatic logic [31:0] read_word(input mil_sel_e s, input mil_top_s q);
        read_word = '0;
        case (s)
            MIL_SEL_CTRL:  read_word[7:0] = q.ctrl;
            MIL_SEL_PFLAG: read_word[`MIL_PFLAG_CONV] = q.pflag;
            MIL_SEL_PEN:   read_word[`MIL_PEN_CONV] = q.pen;
            MIL_SEL_STAT:  read_word[`MIL_STAT_W-1:0] = q.stat;
            MIL_SEL_MASK:  read_word[`MIL_STAT_W-1:0] = q.mask;
            default:       read_word = '0;
        endcase
    endfunction

    mil_sync #(
        .W (4)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({ext_irq_pin, port_pins}),
        .sync_out ({ext_s, port_s})
    );

    // global enable and any enabled flag
    always_comb begin
        request = r.ctrl[`MIL_CTRL_GLOBAL] & (
            (r.ctrl[`MIL_CTRL_TMR_EN]  & r.ctrl[`MIL_CTRL_TMR_FLG])  |
            (r.ctrl[`MIL_CTRL_EXT_EN]  & r.ctrl[`MIL_CTRL_EXT_FLG])  |
            (r.ctrl[`MIL_CTRL_PORT_EN] & r.ctrl[`MIL_CTRL_PORT_FLG]) |
            (r.ctrl[`MIL_CTRL_PERIPH]  & r.pen & r.pflag));
    end

    mil_latency #(
        .LAT_CYCLES (`MIL_LAT_CYCLES)
    ) u_latency (
        .pclk         (pclk),
        .presetn      (presetn),
        .cycle_strobe (cycle_strobe),
        .request      (request),
        .take         (lat_take)
    );

    always_comb begin
        logic     setup;
        logic     wr;
        mil_sel_e sel;
        logic     ext_edge;
        logic     port_chg;
        setup    = 1'b0;
        wr       = 1'b0;
        sel      = MIL_SEL_NONE;
        ext_edge = 1'b0;
        port_chg = 1'b0;
        next_r   = r;

        sel   = decode(paddr);
        setup = psel & ~penable;
        wr    = psel & penable & r.pready & pwrite;

        // pin events wait until sync stages and history hold real levels
        ext_edge = r.primed[2] & (EXT_RISING ? (ext_s & ~r.ext_prev) : (~ext_s & r.ext_prev));
        port_chg = r.primed[2] & (|(port_s ^ r.port_prev));
        next_r.ext_prev  = ext_s;
        next_r.port_prev = port_s;
        next_r.primed    = {r.primed[1:0], 1'b1};

        // software writes first, hardware sets override
        if (wr && sel == MIL_SEL_CTRL) begin
            next_r.ctrl = pwdata[7:0];
        end
        if (wr && sel == MIL_SEL_PFLAG) begin
            next_r.pflag = pwdata[`MIL_PFLAG_CONV];
        end
        if (wr && sel == MIL_SEL_PEN) begin
            next_r.pen = pwdata[`MIL_PEN_CONV];
        end
        if (wr && sel == MIL_SEL_MASK) begin
            next_r.mask = pwdata[`MIL_STAT_W-1:0];
        end
        if (wr && sel == MIL_SEL_STAT) begin
            next_r.stat = r.stat & ~pwdata[`MIL_STAT_W-1:0];
        end

        // sticky flags, independent of enables
        if (timer_zero_ovf) begin
            next_r.ctrl[`MIL_CTRL_TMR_FLG] = 1'b1;
        end
        if (ext_edge) begin
            next_r.ctrl[`MIL_CTRL_EXT_FLG] = 1'b1;
        end
        if (port_chg) begin
            next_r.ctrl[`MIL_CTRL_PORT_FLG] = 1'b1;
        end
        if (conv_done) begin
            next_r.pflag = 1'b1;
        end

        // return re-enables, accept disables and wins
        if (return_from_irq_instr) begin
            next_r.ctrl[`MIL_CTRL_GLOBAL] = 1'b1;
            next_r.stat[`MIL_STAT_RETURN] = 1'b1;
        end
        if (lat_take) begin
            next_r.ctrl[`MIL_CTRL_GLOBAL] = 1'b0;
            next_r.stat[`MIL_STAT_TAKEN]  = 1'b1;
        end

        // core vectoring pulses and constant vector address
        next_r.vector_take = lat_take;
        next_r.push_return = lat_take;
        next_r.pc_load     = lat_take;
        next_r.pc_vector   = `MIL_VECTOR_ADDR;

        next_r.irq = |(next_r.stat & next_r.mask);

        // apb: answer ready in the first access cycle
        next_r.pready  = setup;
        next_r.pslverr = setup & (sel == MIL_SEL_NONE);
        next_r.prdata  = (setup && !pwrite) ? read_word(sel, r) : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r           <= '0;
            r.ctrl      <= `MIL_CTRL_RST;
            r.pflag     <= `MIL_PFLAG_RST;
            r.pen       <= `MIL_PEN_RST;
            r.stat      <= `MIL_STAT_RST;
            r.mask      <= `MIL_MASK_RST;
            r.pc_vector <= `MIL_VECTOR_ADDR;
        end else begin
            r <= next_r;
        end
    end

    assign prdata      = r.prdata;
    assign pready      = r.pready;
    assign pslverr     = r.pslverr;
    assign vector_take = r.vector_take;
    assign push_return = r.push_return;
    assign pc_load     = r.pc_load;
    assign pc_vector   = r.pc_vector;
    assign irq         = r.irq;
endmodule

`default_nettype wire

/* hdl/mil_params.svh */
// Functional notes
// - exactly four request sources
// - flags set regardless of any enable
// - global enable bit 7 gates all vectoring requests
// - enabled flag with global enable vectors
// - each source masked by own enable
// - reset clears the global enable
// - return instruction sets global enable again
// - pin, port, timer flags in control register
// - converter flag gated by peripheral enables
// - accept: clear enable, push, load 0004h
// - event to vector three or four cycles
// - latency independent of instruction length
`ifndef MIL_PARAMS_SVH
`define MIL_PARAMS_SVH

`define MIL_ADDR_W        12
`define MIL_OFF_CTRL      12'h000
`define MIL_OFF_PFLAG     12'h004
`define MIL_OFF_PEN       12'h008
`define MIL_OFF_STAT      12'h00c
`define MIL_OFF_MASK      12'h010

`define MIL_CTRL_GLOBAL   7
`define MIL_CTRL_PERIPH   6
`define MIL_CTRL_TMR_EN   5
`define MIL_CTRL_EXT_EN   4
`define MIL_CTRL_PORT_EN  3
`define MIL_CTRL_TMR_FLG  2
`define MIL_CTRL_EXT_FLG  1
`define MIL_CTRL_PORT_FLG 0
`define MIL_CTRL_RST      8'h00

`define MIL_PFLAG_CONV    0
`define MIL_PEN_CONV      0
`define MIL_PFLAG_RST     1'h0
`define MIL_PEN_RST       1'h0

`define MIL_STAT_W        2
`define MIL_STAT_TAKEN    0
`define MIL_STAT_RETURN   1
`define MIL_STAT_RST      2'h0
`define MIL_MASK_RST      2'h0

`define MIL_PC_W          13
`define MIL_VECTOR_ADDR   13'h0004
`define MIL_LAT_CYCLES    3
`define MIL_LAT_CNT_W     2

`endif

/* hdl/mil_pkg.sv */
`include "mil_params.svh"

package mil_pkg;

    typedef enum logic [1:0] {
        MIL_LAT_IDLE  = 2'h0,
        MIL_LAT_COUNT = 2'h1,
        MIL_LAT_FIRE  = 2'h3
    } mil_lat_state_e;

    typedef enum logic [2:0] {
        MIL_SEL_CTRL  = 3'h0,
        MIL_SEL_PFLAG = 3'h1,
        MIL_SEL_PEN   = 3'h2,
        MIL_SEL_STAT  = 3'h3,
        MIL_SEL_MASK  = 3'h4,
        MIL_SEL_NONE  = 3'h7
    } mil_sel_e;

    typedef logic [`MIL_ADDR_W-1:0] mil_addr_t;
    typedef logic [`MIL_PC_W-1:0]   mil_pc_t;

    typedef struct packed {
        mil_lat_state_e               state;
        logic [`MIL_LAT_CNT_W-1:0]    cnt;
        logic                         take;
    } mil_lat_s;

    typedef struct packed {
        logic [7:0]                   ctrl;
        logic                         pflag;
        logic                         pen;
        logic [`MIL_STAT_W-1:0]       stat;
        logic [`MIL_STAT_W-1:0]       mask;
        logic                         ext_prev;
        logic [2:0]                   port_prev;
        logic [2:0]                   primed;
        logic [31:0]                  prdata;
        logic                         pready;
        logic                         pslverr;
        logic                         irq;
        logic                         vector_take;
        logic                         push_return;
        logic                         pc_load;
        mil_pc_t                      pc_vector;
    } mil_top_s;

endpackage

/* hdl/mil_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module mil_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // pins in, synchronised out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } mil_sync_s;

    mil_sync_s r;
    mil_sync_s next_r;

    always_comb begin
        next_r    = r;
        next_r.s1 = async_in;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sync_out = r.s2;
endmodule

`default_nettype wire

/* hdl/mil_latency.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mil_params.svh"

module mil_latency #(
    parameter int LAT_CYCLES = `MIL_LAT_CYCLES
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // instruction cycle boundary from the core
    input  wire logic cycle_strobe,
    // qualified request and accept pulse
    input  wire logic request,
    output logic      take
);
    import mil_pkg::*;

    mil_lat_s r;
    mil_lat_s next_r;

    // counts cycle boundaries, not instruction ends
    always_comb begin
        next_r      = r;
        next_r.take = 1'b0;
        case (r.state)
            MIL_LAT_IDLE: begin
                if (request) begin
                    next_r.state = MIL_LAT_COUNT;
                    next_r.cnt   = '0;
                end
            end
            MIL_LAT_COUNT: begin
                if (!request) begin
                    next_r.state = MIL_LAT_IDLE;
                end else if (cycle_strobe) begin
                    if (r.cnt == LAT_CYCLES[`MIL_LAT_CNT_W-1:0]) begin
                        next_r.take  = 1'b1;
                        next_r.state = MIL_LAT_FIRE;
                    end else begin
                        next_r.cnt = r.cnt + `MIL_LAT_CNT_W'(1);
                    end
                end
            end
            MIL_LAT_FIRE: begin
                next_r.state = MIL_LAT_IDLE;
            end
            default: begin
                next_r.state = MIL_LAT_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{state: MIL_LAT_IDLE, cnt: '0, take: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign take = r.take;
endmodule

`default_nettype wire

/* verif/mil_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module mil_top_chk (
    // clock, reset, apb
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    // core link
    input wire logic             cycle_strobe,
    input wire logic             vector_take,
    input wire logic             push_return,
    input wire logic             pc_load,
    input wire mil_pkg::mil_pc_t pc_vector,
    input wire logic             irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    take_push_a: assert property (vector_take |-> push_return && pc_load)
        else $error("accept without push and load");
    vec_addr_a: assert property (pc_load |-> pc_vector == 13'h0004)
        else $error("wrong vector address");
    take_once_a: assert property (vector_take |=> !vector_take [*4])
        else $error("accept repeated");
    take_strobe_a: assert property (vector_take |->
        $past(cycle_strobe) || $past(cycle_strobe, 2) || $past(cycle_strobe, 3))
        else $error("accept off a cycle boundary");
    reset_quiet_a: assert property ($rose(presetn) |->
        !vector_take && !irq && pc_vector == 13'h0004)
        else $error("outputs busy after reset");
    reset_hold_a: assert property ($rose(presetn) |-> !vector_take [*8])
        else $error("accept soon after reset");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    rdata_idle_a: assert property (prdata != 32'h0 |-> psel && penable && !pwrite)
        else $error("read data outside read access");
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");

    cover property (vector_take);
    cover property (pslverr);
    cover property ($rose(irq));
endmodule

bind mil_top mil_top_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
    .pready, .pslverr, .cycle_strobe, .vector_take, .push_return, .pc_load, .pc_vector,
    .irq);
`default_nettype wire

/* verif/mil_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mil_core_model (
    // clock, reset, bench control
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             slow,
    input  wire logic             ret_req,
    // from the block
    input  wire logic             push_return,
    input  wire logic             pc_load,
    input  wire mil_pkg::mil_pc_t pc_vector,
    // to the block and the bench
    output logic                  cycle_strobe,
    output logic                  return_from_irq_instr,
    output mil_pkg::mil_pc_t      pc,
    output logic [3:0]            depth
);
    logic [2:0] cnt;
    // one boundary per instruction cycle, period 4 or 8 clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 3'h0;
            cycle_strobe <= 1'b0;
            return_from_irq_instr <= 1'b0;
            pc <= 13'h1fff;
            depth <= 4'h0;
        end else begin
            cnt <= (cnt == {slow, 2'h3}) ? 3'h0 : cnt + 3'h1;
            cycle_strobe <= (cnt == 3'h0);
            return_from_irq_instr <= ret_req;
            if (pc_load) pc <= pc_vector;
            depth <= depth + {3'h0, push_return} - {3'h0, ret_req};
        end
    end
endmodule
`default_nettype wire

/* verif/mil_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module mil_top_tb_top;
    import mil_pkg::*;
    typedef struct packed {
        mil_addr_t   a;
        logic [31:0] w;
        logic [31:0] r;
        logic        e;
    } mil_row_s;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, irq;
    logic        timer_zero_ovf, conv_done, ext_irq_pin, cycle_strobe, slow, ret_req;
    logic        return_from_irq_instr, vector_take, push_return, pc_load;
    logic [2:0]  port_pins;
    logic [3:0]  depth;
    logic [31:0] pwdata, prdata, rd;
    mil_addr_t   paddr;
    mil_pc_t     pc_vector, pc;
    int          n_fail, n_compared, s;
    mil_row_s    rows [8] = '{'{12'h000, 32'h7f, 32'h7f, 1'b0}, '{12'h000, 32'hffffff00, 32'h0, 1'b0},
        '{12'h004, 32'hffffffff, 32'h1, 1'b0}, '{12'h008, 32'hffffffff, 32'h1, 1'b0},
        '{12'h004, 32'h0, 32'h0, 1'b0}, '{12'h010, 32'hffffffff, 32'h3, 1'b0},
        '{12'h00c, 32'h3, 32'h0, 1'b0}, '{12'h014, 32'h5, 32'h0, 1'b1}};

    mil_top i_mil_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .timer_zero_ovf, .conv_done, .ext_irq_pin, .port_pins,
        .cycle_strobe, .return_from_irq_instr, .vector_take, .push_return, .pc_load,
        .pc_vector, .irq);
    mil_core_model i_mil_core_model (.pclk, .presetn, .slow, .ret_req, .push_return,
        .pc_load, .pc_vector, .cycle_strobe, .return_from_irq_instr, .pc, .depth);

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, g, x);
        end
    endtask

    task apb(input logic w, input mil_addr_t a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        // answer taken at the rising edge where pready stands
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            $display("Error %0t: no pready", $time);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdc(input mil_addr_t a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rd, x);
    endtask

    task evt(input int k);
        @(posedge pclk);
        if (k == 0) timer_zero_ovf <= 1'b1;
        else conv_done <= 1'b1;
        @(posedge pclk);
        timer_zero_ovf <= 1'b0;
        conv_done <= 1'b0;
    endtask

    // boundaries seen until accept, 99 when none comes
    task wt(output int n);
        int c;
        n = 0;
        c = 0;
        while (vector_take !== 1'b1 && c < 120) begin
            @(negedge pclk);
            c++;
            if (cycle_strobe === 1'b1) n++;
        end
        if (c == 120) n = 99;
        @(negedge pclk);
    endtask

    task complete_run;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        $display("Error %0t: watchdog expired", $time);
        complete_run;
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, slow, ret_req} = '0;
        {timer_zero_ovf, conv_done, ext_irq_pin, port_pins} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w);
            chk(er, rows[i].e);
            rdc(rows[i].a, rows[i].r);
            chk(er, rows[i].e);
        end
        apb(1'b1, 12'h000, 32'h80);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        rdc(12'h000, 32'h0);
        rdc(12'h008, 32'h0);
        apb(1'b1, 12'h010, 32'h3);
        apb(1'b1, 12'h008, 32'h1);
        evt(0);
        rdc(12'h000, 32'h04);
        apb(1'b1, 12'h000, 32'h24);
        wt(s);
        chk(s, 99);
        apb(1'b1, 12'h000, 32'h84);
        evt(0);
        wt(s);
        chk(s, 99);
        rdc(12'h000, 32'h84);
        apb(1'b1, 12'h000, 32'ha4);
        wt(s);
        chk(s != 99, 1'b1);
        chk(pc, 13'h0004);
        chk(depth, 4'h1);
        rdc(12'h000, 32'h24);
        chk(irq, 1'b1);
        apb(1'b1, 12'h00c, 32'h1);
        rdc(12'h00c, 32'h0);
        chk(irq, 1'b0);
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h000, 32'h20);
        @(posedge pclk);
        ret_req <= 1'b1;
        @(posedge pclk);
        ret_req <= 1'b0;
        repeat (2) @(posedge pclk);
        rdc(12'h000, 32'ha0);
        chk(depth, 4'h0);
        wt(s);
        chk(s, 99);
        evt(1);
        rdc(12'h004, 32'h1);
        wt(s);
        chk(s, 99);
        apb(1'b1, 12'h000, 32'he0);
        wt(s);
        chk(s != 99, 1'b1);
        rdc(12'h00c, 32'h3);
        chk(irq, 1'b0);
        apb(1'b1, 12'h004, 32'h0);
        for (int k = 0; k < 8; k++) begin
            slow <= k[2];
            apb(1'b1, 12'h000, 32'h88);
            repeat (k % 4) @(posedge pclk);
            port_pins <= ~port_pins;
            wt(s);
            // first boundary closes the cycle the event landed in
            chk(s == 4 || s == 5, 1'b1);
            rdc(12'h000, 32'h09);
        end
        apb(1'b1, 12'h000, 32'h90);
        @(posedge pclk);
        ext_irq_pin <= 1'b1;
        wt(s);
        chk(s != 99, 1'b1);
        rdc(12'h000, 32'h12);
        complete_run;
    end
endmodule
`default_nettype wire
